// file: add_bit_datapath.sv
// add, and, bit set/clear and bit-test-skip execution datapath
// Operation
// RULE1 - add literal sums the accumulator and an 8-bit literal into the accumulator, setting carry, nibble carry and zero.
// RULE2 - add file sums the accumulator and the addressed file register, sends it to the destination, setting carry, nibble carry and zero.
// RULE3 - and literal ands the accumulator with an 8-bit literal into the accumulator and changes only zero.
// RULE4 - and file ands the accumulator with the addressed file register into the destination and changes only zero.
// RULE5 - a destination of zero writes the accumulator and a destination of one writes the file register back.
// RULE6 - bit clear forces the chosen bit 0..7 of the file register low and leaves other bits and flags alone.
// RULE7 - bit set forces the chosen bit of the file register high and leaves other bits and flags alone.
// RULE8 - skip if zero runs on when the bit is one, and when it is zero discards the next instruction with an idle slot.
// RULE9 - skip if one runs on when the bit is zero, and when it is one discards the next instruction with an idle slot, flags kept.
// RULE10 - a read-modify-write of the i/o port register reads the pin levels, not the output latch.
// RULE11 - zero is set for an all-zero result and nibble carry is the carry out of bit 3 on adds.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "add_bit_params.svh"
module add_bit_datapath (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  // instruction issue
  input  wire logic       OP_VALID_I,
  input  wire logic [2:0] OP_CODE_I,
  input  wire logic [6:0] FILE_ADDR_I,
  input  wire logic [2:0] BIT_SEL_I,
  input  wire logic       DEST_I,
  input  wire logic [7:0] LITERAL_I,
  output logic            OP_READY_O,
  output logic            DONE_O,
  output logic            SKIP_O,
  // i/o port
  input  wire logic [7:0] PORT_PINS_I,
  output logic [7:0]      PORT_LATCH_O,
  // register bus
  input  wire logic [7:0] BUS_ADDR_I,
  input  wire logic [7:0] BUS_WDATA_I,
  input  wire logic       BUS_WR_I,
  input  wire logic       BUS_RD_I,
  output logic [7:0]      BUS_RDATA_O
);
  add_bit_pkg::state_e state;
  add_bit_pkg::state_e next_state;
  add_bit_pkg::op_e    op;
  logic [6:0]          faddr;
  logic [2:0]          bsel;
  logic                dest;
  logic [7:0]          lit;
  logic [7:0]          acc;
  logic                c_flag;
  logic                nib_flag;
  logic                z_flag;
  logic [7:0]          operand;
  logic [7:0]          alu_b;
  logic [7:0]          alu_res;
  logic                alu_c;
  logic                alu_nc;
  logic [7:0]          bit_mask;
  logic [7:0]          bit_res;
  logic                bit_hit;
  logic                ex;
  logic                is_add;
  logic                is_arith;
  logic                is_bitwr;
  logic                acc_we;
  logic                skip_hit;
  logic                bus_file;
  logic                bus_wr_acc;
  logic                bus_wr_stat;
  logic [7:0]          status_word;
  logic [7:0]          rd_reg;
  logic                rd_sel_file;

  file_mem_if #(.AW(7), .DW(8)) mi ();

  file_mem #(.DEPTH(128)) u_mem (
    .clk (CLK_I),
    .mi  (mi)
  );

  alu8 u_alu (
    .use_and      (op == add_bit_pkg::AND_LITERAL_OP || op == add_bit_pkg::AND_FILE_OP),
    .a            (acc),
    .b            (alu_b),
    .res          (alu_res),
    .carry        (alu_c),
    .nibble_carry (alu_nc)
  );

  // bus decode; the top address bit splits file space from core registers
  assign bus_file    = !BUS_ADDR_I[`FILE_TOP_BIT];
  assign bus_wr_acc  = BUS_WR_I && BUS_ADDR_I == `ACC_OFS;
  assign bus_wr_stat = BUS_WR_I && BUS_ADDR_I == `STATUS_OFS;

  // operand select: pins stand in for the port latch
  always_comb begin
    operand  = (faddr == `IO_PORT_ADDR) ? PORT_PINS_I : mi.rd_data; // see RULE10
    alu_b    = add_bit_pkg::uses_file(op) ? operand : lit;
    bit_mask = 8'h01 << bsel;
    bit_hit  = operand[bsel];
    bit_res  = (op == add_bit_pkg::BIT_SET_OP) ? (operand | bit_mask) // see RULE7
                                               : (operand & ~bit_mask); // see RULE6
  end

  // per-op decode of the execute cycle
  always_comb begin
    ex       = state == add_bit_pkg::ST_EXEC;
    is_add   = op == add_bit_pkg::ADD_LITERAL_OP || op == add_bit_pkg::ADD_FILE_OP;
    is_arith = is_add || op == add_bit_pkg::AND_LITERAL_OP || op == add_bit_pkg::AND_FILE_OP;
    is_bitwr = op == add_bit_pkg::BIT_CLEAR_OP || op == add_bit_pkg::BIT_SET_OP;
    acc_we   = ex && is_arith && (!add_bit_pkg::uses_file(op) || !dest); // see RULE5
    skip_hit = ex && ((op == add_bit_pkg::SKIP_IF_BIT_ZERO_OP && !bit_hit) // see RULE8
                   || (op == add_bit_pkg::SKIP_IF_BIT_ONE_OP && bit_hit)); // see RULE9
  end

  // memory ports; a bus file read holds the fetch off for a cycle
  always_comb begin
    mi.exec_we    = ex && ((is_arith && add_bit_pkg::uses_file(op) && dest) // see RULE5
                        || is_bitwr);
    mi.exec_addr  = faddr;
    mi.exec_wdata = is_bitwr ? bit_res : alu_res; // see RULE2
    mi.bus_we     = BUS_WR_I && bus_file;
    mi.bus_addr   = BUS_ADDR_I[6:0];
    mi.bus_wdata  = BUS_WDATA_I;
    mi.rd_en      = (BUS_RD_I && bus_file) || state == add_bit_pkg::ST_FETCH;
    mi.rd_addr    = (BUS_RD_I && bus_file) ? BUS_ADDR_I[6:0] : faddr;
  end

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      add_bit_pkg::ST_IDLE: begin
        if (OP_VALID_I) begin
          next_state = add_bit_pkg::uses_file(add_bit_pkg::op_e'(OP_CODE_I))
                       ? add_bit_pkg::ST_FETCH : add_bit_pkg::ST_EXEC;
        end
      end
      add_bit_pkg::ST_FETCH: begin
        if (!(BUS_RD_I && bus_file)) begin
          next_state = add_bit_pkg::ST_EXEC;
        end
      end
      add_bit_pkg::ST_EXEC: begin
        next_state = skip_hit ? add_bit_pkg::ST_IDLE_SLOT : add_bit_pkg::ST_IDLE;
      end
      add_bit_pkg::ST_IDLE_SLOT: next_state = add_bit_pkg::ST_IDLE;
      default: next_state = add_bit_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= add_bit_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign OP_READY_O = state == add_bit_pkg::ST_IDLE;

  // instruction fields held for the whole operation
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      op    <= add_bit_pkg::ADD_LITERAL_OP;
      faddr <= 7'h00;
      bsel  <= 3'h0;
      dest  <= 1'b0;
      lit   <= 8'h00;
    end else if (OP_VALID_I && OP_READY_O) begin
      op    <= add_bit_pkg::op_e'(OP_CODE_I);
      faddr <= FILE_ADDR_I;
      bsel  <= BIT_SEL_I;
      dest  <= DEST_I;
      lit   <= LITERAL_I;
    end
  end

  // accumulator: the executing op beats a bus write in the same cycle
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      acc <= `ACC_RST;
    end else if (acc_we) begin
      acc <= alu_res; // see RULE1
    end else if (bus_wr_acc) begin
      acc <= BUS_WDATA_I;
    end
  end

  // flags: adds touch all three, ands only zero, bit ops none
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      c_flag   <= 1'b0;
      nib_flag <= 1'b0;
      z_flag   <= 1'b0;
    end else begin
      if (ex && is_add) begin
        c_flag   <= alu_c; // see RULE1
        nib_flag <= alu_nc; // see RULE11
      end else if (bus_wr_stat) begin
        c_flag   <= BUS_WDATA_I[`C_BIT];
        nib_flag <= BUS_WDATA_I[`NIB_BIT];
      end
      if (ex && is_arith) begin
        z_flag <= add_bit_pkg::zero_of(alu_res); // see RULE3 RULE4 RULE11
      end else if (bus_wr_stat) begin
        z_flag <= BUS_WDATA_I[`Z_BIT];
      end
    end
  end

  // output latch mirrors writes to the port address
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PORT_LATCH_O <= `LATCH_RST;
    end else if (mi.exec_we && faddr == `IO_PORT_ADDR) begin
      PORT_LATCH_O <= mi.exec_wdata; // see RULE10
    end else if (mi.bus_we && BUS_ADDR_I[6:0] == `IO_PORT_ADDR) begin
      PORT_LATCH_O <= BUS_WDATA_I;
    end
  end

  // completion report; skip comes with done after the idle slot
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DONE_O <= 1'b0;
      SKIP_O <= 1'b0;
    end else begin
      DONE_O <= (ex && !skip_hit) || state == add_bit_pkg::ST_IDLE_SLOT;
      SKIP_O <= state == add_bit_pkg::ST_IDLE_SLOT; // see RULE8
    end
  end

  // status view; busy shows the sequencer is occupied
  always_comb begin
    status_word            = 8'h00;
    status_word[`C_BIT]    = c_flag;
    status_word[`NIB_BIT]  = nib_flag;
    status_word[`Z_BIT]    = z_flag;
    status_word[`BUSY_BIT] = state != add_bit_pkg::ST_IDLE;
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_reg      <= 8'h00;
      rd_sel_file <= 1'b0;
    end else begin
      rd_sel_file <= BUS_RD_I && bus_file;
      if (BUS_RD_I && BUS_ADDR_I == `ACC_OFS) begin
        rd_reg <= acc;
      end else if (BUS_RD_I && BUS_ADDR_I == `STATUS_OFS) begin
        rd_reg <= status_word;
      end else begin
        rd_reg <= 8'h00;
      end
    end
  end

  assign BUS_RDATA_O = rd_sel_file ? mi.rd_data : rd_reg;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  chk_add_literal: assert property ( // see RULE1
    ex && op == add_bit_pkg::ADD_LITERAL_OP |=> acc == 8'($past(acc) + $past(lit)))
    else $error("add literal result wrong");

  chk_add_file_carry: assert property ( // see RULE2
    ex && op == add_bit_pkg::ADD_FILE_OP
    |=> c_flag == ((9'($past(acc)) + 9'($past(operand))) > 9'h0FF))
    else $error("add file carry wrong");

  chk_and_literal_flags: assert property ( // see RULE3
    ex && op == add_bit_pkg::AND_LITERAL_OP && !bus_wr_stat
    |=> acc == ($past(acc) & $past(lit)) && $stable(c_flag) && $stable(nib_flag))
    else $error("and literal result or flags wrong");

  chk_and_file_write: assert property ( // see RULE4
    ex && op == add_bit_pkg::AND_FILE_OP && dest
    |-> mi.exec_we && mi.exec_wdata == (acc & operand))
    else $error("and file write back wrong");

  chk_dest_acc: assert property ( // see RULE5
    ex && is_arith && add_bit_pkg::uses_file(op) && !dest |-> !mi.exec_we ##1 acc == $past(alu_res))
    else $error("destination zero misrouted");

  chk_bit_clear: assert property ( // see RULE6
    ex && op == add_bit_pkg::BIT_CLEAR_OP && !bus_wr_stat
    |-> mi.exec_wdata == (operand & ~(8'h01 << bsel)) ##1 $stable(status_word[2:0]))
    else $error("bit clear wrong");

  chk_bit_set: assert property ( // see RULE7
    ex && op == add_bit_pkg::BIT_SET_OP |-> mi.exec_we && mi.exec_wdata[bsel]
    && mi.exec_wdata == (operand | (8'h01 << bsel)))
    else $error("bit set wrong");

  chk_skip_zero_path: assert property ( // see RULE8
    ex && op == add_bit_pkg::SKIP_IF_BIT_ZERO_OP && !operand[bsel]
    |=> !DONE_O ##1 DONE_O && SKIP_O)
    else $error("skip if zero did not insert idle slot");

  chk_skip_one_path: assert property ( // see RULE9
    ex && op == add_bit_pkg::SKIP_IF_BIT_ONE_OP
    |=> (DONE_O && !SKIP_O) == !$past(operand[bsel]))
    else $error("skip if one took the wrong path");

  chk_port_pins: assert property ( // see RULE10
    ex && is_bitwr && faddr == `IO_PORT_ADDR
    |=> (PORT_LATCH_O & ~$past(bit_mask)) == ($past(PORT_PINS_I) & ~$past(bit_mask)))
    else $error("port read did not use pin levels");

  chk_zero_flag: assert property ( // see RULE11
    ex && is_arith && !bus_wr_stat |=> z_flag == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");

  cov_add_carry: cover property (ex && is_add && alu_c && alu_nc);
  cov_skip_taken: cover property (state == add_bit_pkg::ST_IDLE_SLOT);
  cov_port_rmw: cover property (mi.exec_we && faddr == `IO_PORT_ADDR);
  cov_fetch_stall: cover property (state == add_bit_pkg::ST_FETCH && BUS_RD_I && bus_file);
endmodule : add_bit_datapath
`default_nettype wire

// file: add_bit_params.svh
// offsets, field positions and reset values of the add and bit-op datapath
`ifndef ADD_BIT_PARAMS_SVH
`define ADD_BIT_PARAMS_SVH

// register bus map: 0x00..0x7F file registers, then core registers
`define ACC_OFS      8'h80
`define STATUS_OFS   8'h81
`define FILE_TOP_BIT 7

// status field positions
`define C_BIT    0
`define NIB_BIT  1
`define Z_BIT    2
`define BUSY_BIT 7

// reset values
`define ACC_RST   8'h00
`define LATCH_RST 8'h00

// file address that maps onto the i/o port pins
`define IO_PORT_ADDR 7'h05

`endif

// file: add_bit_pkg.sv
// types and helpers shared by the add and bit-op datapath
`default_nettype none
package add_bit_pkg;

  typedef enum logic [2:0] {
    ADD_LITERAL_OP      = 3'h0,
    ADD_FILE_OP         = 3'h1,
    AND_LITERAL_OP      = 3'h2,
    AND_FILE_OP         = 3'h3,
    BIT_CLEAR_OP        = 3'h4,
    BIT_SET_OP          = 3'h5,
    SKIP_IF_BIT_ZERO_OP = 3'h6,
    SKIP_IF_BIT_ONE_OP  = 3'h7
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_FETCH     = 2'h1,
    ST_EXEC      = 2'h2,
    ST_IDLE_SLOT = 2'h3
  } state_e;

  // literal ops never touch the file space
  function automatic logic uses_file(input op_e op);
    return !(op == ADD_LITERAL_OP || op == AND_LITERAL_OP);
  endfunction : uses_file

  function automatic logic zero_of(input logic [7:0] v);
    return v == 8'h00;
  endfunction : zero_of

endpackage : add_bit_pkg
`default_nettype wire

// file: file_mem_if.sv
// carrier between the datapath control and the file register memory
`timescale 1ns/100ps
`default_nettype none
interface file_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic          exec_we;
  logic [AW-1:0] exec_addr;
  logic [DW-1:0] exec_wdata;
  logic          bus_we;
  logic [AW-1:0] bus_addr;
  logic [DW-1:0] bus_wdata;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (output exec_we, exec_addr, exec_wdata, bus_we, bus_addr, bus_wdata,
                output rd_en, rd_addr, input rd_data);
  modport mem  (input exec_we, exec_addr, exec_wdata, bus_we, bus_addr, bus_wdata,
                input rd_en, rd_addr, output rd_data);
endinterface : file_mem_if
`default_nettype wire

// file: file_mem.sv
// file register memory: two write ports, one registered read port
`timescale 1ns/100ps
`default_nettype none
module file_mem #(
  parameter int DEPTH = 128
) (
  // clock
  input wire logic   clk,
  // access
  file_mem_if.mem    mi
);
  logic [7:0] store [DEPTH];

  // execution write comes second so it wins a same-address clash
  always_ff @(posedge clk) begin
    if (mi.bus_we) begin
      store[mi.bus_addr] <= mi.bus_wdata;
    end
    if (mi.exec_we) begin
      store[mi.exec_addr] <= mi.exec_wdata;
    end
  end

  // read data held until the next read
  always_ff @(posedge clk) begin
    if (mi.rd_en) begin
      mi.rd_data <= store[mi.rd_addr];
    end
  end
endmodule : file_mem
`default_nettype wire

// file: alu8.sv
// 8-bit add / and unit with carry and nibble carry
`timescale 1ns/100ps
`default_nettype none
module alu8 (
  // operands
  input  wire logic       use_and,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  // result
  output logic [7:0]      res,
  output logic            carry,
  output logic            nibble_carry
);
  logic [8:0] sum9;
  logic [4:0] nib5;

  // nibble carry is the carry out of bit 3
  always_comb begin
    sum9         = {1'b0, a} + {1'b0, b};
    nib5         = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    res          = use_and ? (a & b) : sum9[7:0];
    carry        = sum9[8];
    nibble_carry = nib5[4];
  end
endmodule : alu8
`default_nettype wire

// file: add_bit_datapath_tb.sv
// self-checking testbench for the add, and, bit and skip datapath
`timescale 1ns/100ps
`default_nettype none
`include "add_bit_params.svh"
module add_bit_datapath_tb;
  logic       CLK_I;
  logic       NRST_I;
  logic       OP_VALID_I;
  logic [2:0] OP_CODE_I;
  logic [6:0] FILE_ADDR_I;
  logic [2:0] BIT_SEL_I;
  logic       DEST_I;
  logic [7:0] LITERAL_I;
  logic       OP_READY_O;
  logic       DONE_O;
  logic       SKIP_O;
  logic [7:0] PORT_PINS_I;
  logic [7:0] PORT_LATCH_O;
  logic [7:0] BUS_ADDR_I;
  logic [7:0] BUS_WDATA_I;
  logic       BUS_WR_I;
  logic       BUS_RD_I;
  logic [7:0] BUS_RDATA_O;
  int         mismatches;
  int         cmp_count;

  add_bit_datapath add_bit_datapath_i (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I),
    .FILE_ADDR_I(FILE_ADDR_I), .BIT_SEL_I(BIT_SEL_I), .DEST_I(DEST_I),
    .LITERAL_I(LITERAL_I), .OP_READY_O(OP_READY_O), .DONE_O(DONE_O), .SKIP_O(SKIP_O),
    .PORT_PINS_I(PORT_PINS_I), .PORT_LATCH_O(PORT_LATCH_O), .BUS_ADDR_I(BUS_ADDR_I),
    .BUS_WDATA_I(BUS_WDATA_I), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I),
    .BUS_RDATA_O(BUS_RDATA_O));

  // 125 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // one-cycle write strobe; a gap cycle follows before the next access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    BUS_ADDR_I  <= a;
    BUS_WDATA_I <= d;
    BUS_WR_I    <= 1'b1;
    @(posedge CLK_I);
    BUS_WR_I    <= 1'b0;
  endtask : wr

  // read data only stands in the cycle after the strobe, so sample there
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    BUS_ADDR_I <= a;
    BUS_RD_I   <= 1'b1;
    @(posedge CLK_I);
    BUS_RD_I   <= 1'b0;
    #1;
    check(what, BUS_RDATA_O, exp);
  endtask : rd_chk

  // issue one instruction, count edges to done, judge latency and skip
  task automatic do_op(input add_bit_pkg::op_e op, input logic [6:0] fa, input logic [2:0] b,
                       input logic d, input logic [7:0] lit, input int cyc, input logic skp);
    int n;
    n = 1;
    @(posedge CLK_I);
    OP_VALID_I  <= 1'b1;
    OP_CODE_I   <= op;
    FILE_ADDR_I <= fa;
    BIT_SEL_I   <= b;
    DEST_I      <= d;
    LITERAL_I   <= lit;
    @(posedge CLK_I);
    OP_VALID_I  <= 1'b0;
    #1;
    check("ready low", {7'h00, OP_READY_O}, 8'h00);
    // bounded wait: a lost done must not hang the run; the accept cycle is cycle 1
    while (n < 20) begin
      @(posedge CLK_I);
      #1;
      n++;
      if (DONE_O === 1'b1) break;
    end
    if (n >= 20) begin
      mismatches++;
      $display("CHECK FAILED done timeout expected 1 seen 0");
      tally_and_finish();
    end else begin
      check("cycles", n[7:0], cyc[7:0]);
      check("skip", {7'h00, SKIP_O}, {7'h00, skp});
      check("ready", {7'h00, OP_READY_O}, 8'h01);
    end
  endtask : do_op

  task automatic t_reset();
    rd_chk("acc rst", `ACC_OFS, 8'h00);
    rd_chk("status rst", `STATUS_OFS, 8'h00);
    rd_chk("unmapped", 8'h90, 8'h00);
    check("latch rst", PORT_LATCH_O, 8'h00);
  endtask : t_reset

  task automatic t_add_literal();
    wr(`ACC_OFS, 8'h8F);
    do_op(add_bit_pkg::ADD_LITERAL_OP, 7'h00, 3'h0, 1'b0, 8'h71, 2, 1'b0);
    rd_chk("addlit acc", `ACC_OFS, 8'h00);
    rd_chk("addlit flags", `STATUS_OFS, 8'h07);
    wr(`ACC_OFS, 8'h12);
    do_op(add_bit_pkg::ADD_LITERAL_OP, 7'h00, 3'h0, 1'b0, 8'h34, 2, 1'b0);
    rd_chk("addlit acc2", `ACC_OFS, 8'h46);
    rd_chk("addlit flags2", `STATUS_OFS, 8'h00);
  endtask : t_add_literal

  task automatic t_add_file();
    wr(8'h00, 8'h08);
    wr(`ACC_OFS, 8'h08);
    do_op(add_bit_pkg::ADD_FILE_OP, 7'h00, 3'h0, 1'b0, 8'h00, 3, 1'b0);
    rd_chk("addf acc", `ACC_OFS, 8'h10);
    rd_chk("addf file kept", 8'h00, 8'h08);
    rd_chk("addf flags", `STATUS_OFS, 8'h02);
    do_op(add_bit_pkg::ADD_FILE_OP, 7'h00, 3'h0, 1'b1, 8'h00, 3, 1'b0);
    rd_chk("addf file", 8'h00, 8'h18);
    rd_chk("addf acc kept", `ACC_OFS, 8'h10);
    rd_chk("addf flags2", `STATUS_OFS, 8'h00);
    wr(8'h01, 8'hF0);
    do_op(add_bit_pkg::ADD_FILE_OP, 7'h01, 3'h0, 1'b1, 8'h00, 3, 1'b0);
    rd_chk("addf wrap", 8'h01, 8'h00);
    rd_chk("addf carry", `STATUS_OFS, 8'h05);
  endtask : t_add_file

  task automatic t_and();
    wr(`STATUS_OFS, 8'h03);
    wr(`ACC_OFS, 8'hF0);
    do_op(add_bit_pkg::AND_LITERAL_OP, 7'h00, 3'h0, 1'b0, 8'h0F, 2, 1'b0);
    rd_chk("andlit acc", `ACC_OFS, 8'h00);
    rd_chk("andlit flags", `STATUS_OFS, 8'h07);
    wr(8'h7F, 8'h3C);
    wr(`ACC_OFS, 8'h0F);
    do_op(add_bit_pkg::AND_FILE_OP, 7'h7F, 3'h0, 1'b1, 8'h00, 3, 1'b0);
    rd_chk("andf file", 8'h7F, 8'h0C);
    rd_chk("andf acc kept", `ACC_OFS, 8'h0F);
    rd_chk("andf flags", `STATUS_OFS, 8'h03);
    do_op(add_bit_pkg::AND_FILE_OP, 7'h7F, 3'h0, 1'b0, 8'h00, 3, 1'b0);
    rd_chk("andf acc", `ACC_OFS, 8'h0C);
  endtask : t_and

  // walk every bit position up with clears, then down with sets, at the top file address
  task automatic t_bits();
    logic [7:0] exp;
    exp = 8'hFF;
    wr(`STATUS_OFS, 8'h05);
    wr(8'h7F, exp);
    for (int b = 0; b < 8; b++) begin
      exp[b] = 1'b0;
      do_op(add_bit_pkg::BIT_CLEAR_OP, 7'h7F, b[2:0], 1'b0, 8'h00, 3, 1'b0);
      rd_chk("bit clear", 8'h7F, exp);
    end
    for (int b = 7; b >= 0; b--) begin
      exp[b] = 1'b1;
      do_op(add_bit_pkg::BIT_SET_OP, 7'h7F, b[2:0], 1'b0, 8'h00, 3, 1'b0);
      rd_chk("bit set", 8'h7F, exp);
    end
    rd_chk("bit flags", `STATUS_OFS, 8'h05);
  endtask : t_bits

  // taken skips cost one idle slot on top of the file op latency
  task automatic t_skip();
    logic [7:0] v;
    v = 8'hA5;
    wr(8'h30, v);
    wr(`STATUS_OFS, 8'h02);
    for (int b = 0; b < 8; b++) begin
      do_op(add_bit_pkg::SKIP_IF_BIT_ZERO_OP, 7'h30, b[2:0], 1'b0, 8'h00,
            v[b] ? 3 : 4, ~v[b]);
      do_op(add_bit_pkg::SKIP_IF_BIT_ONE_OP, 7'h30, b[2:0], 1'b0, 8'h00,
            v[b] ? 4 : 3, v[b]);
    end
    rd_chk("skip flags", `STATUS_OFS, 8'h02);
    rd_chk("skip file", 8'h30, v);
  endtask : t_skip

  // latch and pins disagree so a latch-based read shows up
  task automatic t_port();
    PORT_PINS_I <= 8'h0F;
    wr({1'b0, `IO_PORT_ADDR}, 8'hFF);
    #1;
    check("latch wr", PORT_LATCH_O, 8'hFF);
    do_op(add_bit_pkg::BIT_CLEAR_OP, `IO_PORT_ADDR, 3'h0, 1'b0, 8'h00, 3, 1'b0);
    #1;
    check("port rmw", PORT_LATCH_O, 8'h0E);
    rd_chk("port rd", {1'b0, `IO_PORT_ADDR}, 8'h0E);
  endtask : t_port

  // a bus file read in the fetch cycle costs the op one extra cycle
  task automatic t_stall();
    int n;
    n = 2;
    wr(8'h10, 8'h21);
    wr(`ACC_OFS, 8'h01);
    @(posedge CLK_I);
    OP_VALID_I  <= 1'b1;
    OP_CODE_I   <= add_bit_pkg::ADD_FILE_OP;
    FILE_ADDR_I <= 7'h10;
    DEST_I      <= 1'b1;
    @(posedge CLK_I);
    OP_VALID_I  <= 1'b0;
    BUS_ADDR_I  <= 8'h10;
    BUS_RD_I    <= 1'b1;
    @(posedge CLK_I);
    BUS_RD_I    <= 1'b0;
    #1;
    check("stall rd", BUS_RDATA_O, 8'h21);
    while (n < 20 && DONE_O !== 1'b1) begin
      @(posedge CLK_I);
      #1;
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      $display("CHECK FAILED stall done timeout expected 1 seen 0");
      tally_and_finish();
    end else begin
      check("stall cycles", n[7:0], 8'h04);
      rd_chk("stall file", 8'h10, 8'h22);
    end
  endtask : t_stall

  // main sequence
  initial begin
    mismatches  = 0;
    cmp_count   = 0;
    NRST_I      = 1'b0;
    OP_VALID_I  = 1'b0;
    OP_CODE_I   = 3'h0;
    FILE_ADDR_I = 7'h00;
    BIT_SEL_I   = 3'h0;
    DEST_I      = 1'b0;
    LITERAL_I   = 8'h00;
    PORT_PINS_I = 8'h00;
    BUS_ADDR_I  = 8'h00;
    BUS_WDATA_I = 8'h00;
    BUS_WR_I    = 1'b0;
    BUS_RD_I    = 1'b0;
    repeat (6) @(posedge CLK_I);
    NRST_I <= 1'b1;
    t_reset();
    t_add_literal();
    t_add_file();
    t_and();
    t_bits();
    t_skip();
    t_port();
    t_stall();
    tally_and_finish();
  end
endmodule : add_bit_datapath_tb
`default_nettype wire
